// File: hw/capid_consts.vh
// Constants for the capability identification register bank
`ifndef CAPID_CONSTS_VH
`define CAPID_CONSTS_VH

// ==========================================================================
// Register map (byte offsets inside the system-control space)
`define CAPID_ADDR_W 12
`define CAPID_OFS_PIN_CAPS 12'h018
`define CAPID_OFS_PORT_CAPS 12'h01c
`define CAPID_OFS_BASE_HI 20'h400f_e
`define CAPID_BASE_HI_W 20

// ==========================================================================
// Pin-presence fields
`define CAPID_PIN_TIMER_HI 29
`define CAPID_PIN_TIMER_LO 24
`define CAPID_PIN_CONV_HI 19
`define CAPID_PIN_CONV_LO 16
`define CAPID_PIN_FAULT 15
`define CAPID_PIN_CMP_OUT 8
`define CAPID_PIN_CMP_POS 7
`define CAPID_PIN_CMP_NEG 6
`define CAPID_PIN_PULSE_HI 5
`define CAPID_PIN_PULSE_LO 0

// ==========================================================================
// Port-presence fields
`define CAPID_PORT_HI 7
`define CAPID_PORT_LO 0

// ==========================================================================
// Fixed read values
`define CAPID_PIN_CAPS_VAL 32'h3f0f_81ff
`define CAPID_PORT_CAPS_VAL 32'h0000_00ff
`define CAPID_ZERO_WORD 32'h0000_0000

`endif

// File: hw/capid_reset_sync.v
// Reset release synchroniser for the capability register bank
`timescale 1ns/1ps

module capid_reset_sync (
	input wire clk,
	input wire rstn,
	output wire syncRstn
);

	reg stage1_reg;
	reg stage2_reg;

	// ==================================================================
	// Assert at once, release after two edges
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= 1'b1;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncRstn = stage2_reg;

endmodule

// File: hw/capid_rom.v
// Fixed contents of the two capability registers
`timescale 1ns/1ps
`include "capid_consts.vh"

module capid_rom (
	output wire [31:0] pinCaps,
	output wire [31:0] portCaps
);

	// ==================================================================
	// Pin presence: each documented field set, the rest zero
	assign pinCaps[31:30] = 2'h0;
	assign pinCaps[`CAPID_PIN_TIMER_HI:`CAPID_PIN_TIMER_LO] = 6'h3f;
	assign pinCaps[23:20] = 4'h0;
	assign pinCaps[`CAPID_PIN_CONV_HI:`CAPID_PIN_CONV_LO] = 4'hf;
	assign pinCaps[`CAPID_PIN_FAULT] = 1'b1;
	assign pinCaps[14:9] = 6'h00;
	assign pinCaps[`CAPID_PIN_CMP_OUT] = 1'b1;
	assign pinCaps[`CAPID_PIN_CMP_POS] = 1'b1;
	assign pinCaps[`CAPID_PIN_CMP_NEG] = 1'b1;
	assign pinCaps[`CAPID_PIN_PULSE_HI:`CAPID_PIN_PULSE_LO] = 6'h3f;

	// ==================================================================
	// Port presence: ports A to H
	assign portCaps[31:8] = 24'h00_0000;
	assign portCaps[`CAPID_PORT_HI:`CAPID_PORT_LO] = 8'hff;

endmodule

// File: hw/capid_top.v
// Capability register bank on a classic Wishbone slave port
//
// Behaviour
// - Port-presence register at offset 0x01C, 32-bit, read-only, fixed.
// - Port-presence bits 7..0 read one: I/O ports H..A exist.
// - Reserved positions of both registers read zero.
// - Pin-presence bits 29..24 read one: timer capture pins 5..0.
// - Pin-presence bits 19..16 read one: converter inputs 3..0.
// - Pin-presence bit 15 reads one: pulse fault input exists.
// - Pin-presence bits 8,7,6 read one: comparator output, plus, minus.
// - Pin-presence bits 5..0 read one: pulse outputs 5..0.
// - Pin-presence register at offset 0x018, base 0x400F.E000, read-only.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "capid_consts.vh"

module capid_top (
	input wire clk,
	input wire rstn,
	input wire clkEn,
	input wire wbCycI,
	input wire wbStbI,
	input wire wbWeI,
	input wire [31:0] wbAdrI,
	input wire [3:0] wbSelI,
	input wire [31:0] wbDatI,
	output wire wbAckO,
	output wire wbErrO,
	output wire [31:0] wbDatO
);

	wire syncRstn;
	wire [31:0] pinCaps;
	wire [31:0] portCaps;
	reg ack_reg;
	reg err_reg;
	reg [31:0] dat_reg;
	reg [31:0] dat_next;
	reg hit;
	wire request;

	// ==================================================================
	// Address decode, shared by read data and hit detection
	function [1:0] capid_decode;
		input [31:0] adr;
		begin
			capid_decode = 2'b00;
			if (adr[31:`CAPID_ADDR_W] == `CAPID_OFS_BASE_HI) begin
				if (adr[`CAPID_ADDR_W-1:0] == `CAPID_OFS_PIN_CAPS)
					capid_decode = 2'b01;
				else if (adr[`CAPID_ADDR_W-1:0] == `CAPID_OFS_PORT_CAPS)
					capid_decode = 2'b10;
			end
		end
	endfunction

	capid_reset_sync uSync (
		.clk(clk),
		.rstn(rstn),
		.syncRstn(syncRstn)
	);

	capid_rom uRom (
		.pinCaps(pinCaps),
		.portCaps(portCaps)
	);

	// Bus signals come from logic on clk, so no synchroniser on them
	assign request = wbCycI && wbStbI && !ack_reg && !err_reg;

	// ==================================================================
	// Read data mux; write data and byte lanes are ignored
	always @* begin
		dat_next = `CAPID_ZERO_WORD;
		hit = 1'b1;
		case (capid_decode(wbAdrI))
			2'b01: begin
				dat_next = pinCaps;
			end
			2'b10: begin
				dat_next = portCaps;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ==================================================================
	// One-wait-state answer; writes to mapped words are acked and dropped
	always @(posedge clk or negedge syncRstn) begin
		if (!syncRstn) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			dat_reg <= `CAPID_ZERO_WORD;
		end else if (clkEn) begin
			ack_reg <= request && hit;
			err_reg <= request && !hit;
			if (request && hit && !wbWeI)
				dat_reg <= dat_next;
			else if (!request)
				dat_reg <= `CAPID_ZERO_WORD;
		end
	end

	assign wbAckO = ack_reg;
	assign wbErrO = err_reg;
	assign wbDatO = dat_reg;

endmodule

// File: verification/capid_chk.sv
// Assertion checker for the capability register bank
`timescale 1ns/1ps
module capid_chk (
	input wire clk,
	input wire rstn,
	input wire clkEn,
	input wire wbCycI,
	input wire wbStbI,
	input wire wbWeI,
	input wire [31:0] wbAdrI,
	input wire wbAckO,
	input wire wbErrO,
	input wire [31:0] wbDatO
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire go = clkEn && wbCycI && wbStbI && !wbAckO && !wbErrO;
	wire [31:0] a = wbAdrI;
	sequence rdPin; go && !wbWeI && a == 32'h400f_e018; endsequence
	sequence rdPort; go && !wbWeI && a == 32'h400f_e01c; endsequence
	a_pin_word: assert property (rdPin |=> wbAckO && wbDatO == 32'h3f0f_81ff)
		else $error("pin word");
	a_pin_timer: assert property (rdPin |=> wbDatO[29:24] == 6'h3f)
		else $error("timer bits");
	a_pin_conv: assert property (rdPin |=> wbDatO[19:15] == 5'h1f)
		else $error("conv bits");
	a_pin_low: assert property (rdPin |=> wbDatO[8:0] == 9'h1ff)
		else $error("low bits");
	a_pin_rsvd: assert property (rdPin |=>
		!wbDatO[31:30] && !wbDatO[23:20] && !wbDatO[14:9]) else $error("reserved bits");
	a_port_word: assert property (rdPort |=> wbAckO && wbDatO == 32'h0000_00ff)
		else $error("port word");
	a_write_ok: assert property (go && wbWeI && a == 32'h400f_e01c |=>
		wbAckO && !wbErrO) else $error("write");
	a_unmapped: assert property (go && a[31:12] != 20'h400f_e |=>
		wbErrO && !wbAckO) else $error("unmapped");
	a_ack_pulse: assert property (wbAckO |=> !wbAckO)
		else $error("ack pulse");
endmodule
bind capid_top capid_chk capid_chk_i (.*);

// File: verification/testbench.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ps
module testbench;
	reg clk = 0, rstn = 0, cyc = 0, we = 0, e;
	reg [31:0] adr = 0, dat = 0, r = 0;
	wire ack, err;
	wire [31:0] q;
	integer err_total = 0, n_checks = 0, i;
	always #2 clk = ~clk;
	capid_top capid_top_i (.clk(clk), .rstn(rstn), .clkEn(1'h1), .wbCycI(cyc), .wbStbI(cyc),
		.wbWeI(we), .wbAdrI(adr), .wbSelI(4'hf), .wbDatI(dat), .wbAckO(ack), .wbErrO(err),
		.wbDatO(q));
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// Ack is read right after the edge, before that edge's updates land
	task access(input w, input [31:0] a);
		integer k;
		begin
			k = 0;
			cyc <= 1'h1;
			we <= w;
			adr <= a;
			dat <= r;
			do @(posedge clk); while (ack !== 1'h1 && err !== 1'h1 && ++k < 20);
			if (k >= 20) begin
				err_total = err_total + 1;
				print_verdict;
			end
			r = q;
			e = err;
			cyc <= 1'h0;
			we <= 1'h0;
			@(posedge clk);
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'h1;
		repeat (3) @(posedge clk);
		// Second pass reads back after the writes
		for (i = 0; i < 2; i = i + 1) begin
			access(1'h0, 32'h400f_e018);
			check(r, 32'h3f0f_81ff);
			access(1'h0, 32'h400f_e01c);
			check(r, 32'h0000_00ff);
			access(1'h1, 32'h400f_e018);
			check({31'h0, e}, 32'h0);
			access(1'h1, 32'h400f_e01c);
			check({31'h0, e}, 32'h0);
			$display("pass %0d done", i);
		end
		access(1'h0, 32'h400f_e014);
		check({r[30:0], e}, 32'h1);
		$display("unmapped done");
		print_verdict;
	end
endmodule
